/* File: hw/itvf_ctrl.sv */
// Exposure registers with frame-end commit and virtual frame size registers
// Function
// - Exposure count is fourteen bits, two bytes
// - Exposure lasts count plus one rows
// - New count accepted only on toggle flip
// - Commit only at frame boundary, never partial
// - High register: reserved, toggle, count[13:8]
// - Low register holds count bits seven to zero
// - Row depth fourteen bits at 50/51
// - Frame is window plus blanking rows, columns
// - Frame size sets frame period; exposure comes from count only
// - No checking or clamping of frame size
// - Continuous mode exposure ignores window changes
// - Window sits at frame top-left corner
// - Window column width eleven bits, two bytes
// - Column width fourteen bits at 52/53
`timescale 1ns/10ps
module itvf_ctrl
  import itvf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire itvf_wr_s wr_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic frame_end_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output itvf_geom_s geom_o,
  output logic [13:0] blank_rows_base_o,
  output logic [13:0] blank_cols_base_o,
  output logic toggle_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic is_frame_reg(input logic [7:0] a);
    is_frame_reg = (a >= ITVF_ADDR_VRD_HIGH) && (a <= ITVF_ADDR_VCW_LOW);
  endfunction

  logic shadow_low_reg_en;
  logic high_wr;
  logic low_wr;
  logic [7:0] int_high_reg;
  logic [7:0] int_low_reg;
  logic committed_toggle_reg;
  itvf_count_t active_count_reg;
  logic [7:0] mem_rd;
  logic [13:0] rows;
  logic [13:0] cols;
  logic rd_is_mem_reg;
  logic [7:0] rd_local_reg;
  logic rd_pend_reg;
  logic win_high_wr;
  logic win_low_wr;
  logic [2:0] win_width_high_reg;
  logic [7:0] win_width_low_reg;

  assign high_wr = wr_i.en && (wr_i.addr == ITVF_ADDR_INT_HIGH);
  assign low_wr = wr_i.en && (wr_i.addr == ITVF_ADDR_INT_LOW);
  assign shadow_low_reg_en = low_wr;
  assign win_high_wr = wr_i.en && (wr_i.addr == ITVF_ADDR_WIN_WIDTH_HIGH);
  assign win_low_wr = wr_i.en && (wr_i.addr == ITVF_ADDR_WIN_WIDTH_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow integration bytes; all eight bits of the high byte are kept
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      int_high_reg <= {2'h0, ITVF_RST_INT_HIGH};
    else if (high_wr)
      int_high_reg <= wr_i.data;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      int_low_reg <= ITVF_RST_INT_LOW;
    else if (shadow_low_reg_en)
      int_low_reg <= wr_i.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window column width; stored and read back only, exposure never uses it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      win_width_high_reg <= ITVF_RST_WIN_WIDTH_HIGH;
    else if (win_high_wr)
      win_width_high_reg <= wr_i.data[2:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      win_width_low_reg <= ITVF_RST_WIN_WIDTH_LOW;
    else if (win_low_wr)
      win_width_low_reg <= wr_i.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame-boundary commit; writes between frames never leak into the active value
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      committed_toggle_reg <= 1'b0;
      active_count_reg <= {ITVF_RST_INT_HIGH, ITVF_RST_INT_LOW};
    end
    else if (frame_end_i && (int_high_reg[ITVF_BIT_TOGGLE] != committed_toggle_reg))
    begin
      committed_toggle_reg <= int_high_reg[ITVF_BIT_TOGGLE];
      active_count_reg <= {int_high_reg[5:0], int_low_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Virtual frame size store
  itvf_reg_mem u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_i.en && is_frame_reg(wr_i.addr)),
    .wr_idx_i(wr_i.addr[1:0] - ITVF_ADDR_VRD_HIGH[1:0]),
    .wr_data_i(wr_i.data),
    .rd_idx_i(rd_addr_i[1:0] - ITVF_ADDR_VRD_HIGH[1:0]),
    .rd_data_o(mem_rd),
    .rows_o(rows),
    .cols_o(cols)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path, two cycles: a cycle of latency traded for a flopped output
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_pend_reg <= 1'b0;
      rd_is_mem_reg <= 1'b0;
      rd_local_reg <= 8'h00;
    end
    else
    begin
      rd_pend_reg <= rd_en_i;
      rd_is_mem_reg <= is_frame_reg(rd_addr_i);
      if (rd_addr_i == ITVF_ADDR_INT_HIGH)
        rd_local_reg <= int_high_reg;
      else if (rd_addr_i == ITVF_ADDR_INT_LOW)
        rd_local_reg <= int_low_reg;
      else if (rd_addr_i == ITVF_ADDR_WIN_WIDTH_HIGH)
        rd_local_reg <= {5'h00, win_width_high_reg};
      else if (rd_addr_i == ITVF_ADDR_WIN_WIDTH_LOW)
        rd_local_reg <= win_width_low_reg;
      else
        rd_local_reg <= 8'h00;
    end
  end

  // Data stands until the next read answers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_valid_o <= rd_pend_reg;
      if (rd_pend_reg)
        rd_data_o <= rd_is_mem_reg ? mem_rd : rd_local_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Geometry outputs; frame size passed through unchecked, no clamp
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      geom_o <= '0;
      blank_rows_base_o <= 14'h0000;
      blank_cols_base_o <= 14'h0000;
      toggle_o <= 1'b0;
    end
    else
    begin
      geom_o.rows <= rows + ITVF_ONE_14;
      geom_o.cols <= cols + ITVF_ONE_14;
      geom_o.exposure <= active_count_reg + ITVF_ONE_14;
      // Window anchored at origin, so both blanking bases are held at zero
      blank_rows_base_o <= 14'h0000;
      blank_cols_base_o <= 14'h0000;
      toggle_o <= committed_toggle_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_commit_on_flip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (frame_end_i && int_high_reg[ITVF_BIT_TOGGLE] != committed_toggle_reg)
      |=> active_count_reg == $past({int_high_reg[5:0], int_low_reg}))
    else $error("count not committed on toggle flip");
  a_hold_no_flip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(frame_end_i && int_high_reg[ITVF_BIT_TOGGLE] != committed_toggle_reg)
      |=> $stable(active_count_reg))
    else $error("count changed without toggle flip");
  a_no_midframe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !frame_end_i
      |=> $stable(committed_toggle_reg))
    else $error("commit outside frame boundary");
  a_exposure_plus: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1
      |=> geom_o.exposure == $past(active_count_reg) + 14'h0001)
    else $error("exposure not count plus one");
  a_high_stores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    high_wr
      |=> int_high_reg == $past(wr_i.data))
    else $error("high byte not stored");
  a_low_stores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    low_wr
      |=> int_low_reg == $past(wr_i.data))
    else $error("low byte not stored");
  a_rows_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i.en && wr_i.addr == ITVF_ADDR_VRD_LOW) ##1 1'b1
      |=> geom_o.rows[7:0] == $past(wr_i.data, 2) + 8'h01)
    else $error("row depth low byte not applied");
  a_read_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && rd_addr_i == ITVF_ADDR_INT_LOW
      |=> ##1 rd_valid_o && rd_data_o == $past(int_low_reg, 2))
    else $error("low register readback wrong");
  a_win_width_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    win_low_wr
      |=> win_width_low_reg == $past(wr_i.data))
    else $error("window width low byte not stored");
  a_exposure_no_win: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (win_low_wr || win_high_wr) && !frame_end_i
      |=> $stable(active_count_reg))
    else $error("window write changed exposure");
  a_toggle_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1
      |=> toggle_o == $past(committed_toggle_reg))
    else $error("toggle output not committed value");
endmodule // itvf_ctrl

/* File: hw/itvf_pkg.sv */
// Package: register map, field layout, reset values and carriers for the exposure/frame block
package itvf_pkg;
  localparam logic [7:0] ITVF_ADDR_INT_HIGH = 8'h4e;
  localparam logic [7:0] ITVF_ADDR_INT_LOW = 8'h4f;
  localparam logic [7:0] ITVF_ADDR_VRD_HIGH = 8'h50;
  localparam logic [7:0] ITVF_ADDR_VRD_LOW = 8'h51;
  localparam logic [7:0] ITVF_ADDR_VCW_HIGH = 8'h52;
  localparam logic [7:0] ITVF_ADDR_VCW_LOW = 8'h53;
  localparam logic [7:0] ITVF_ADDR_WIN_WIDTH_HIGH = 8'h4b;
  localparam logic [7:0] ITVF_ADDR_WIN_WIDTH_LOW = 8'h4c;
  // Window width reset is a plain default
  localparam logic [2:0] ITVF_RST_WIN_WIDTH_HIGH = 3'h0;
  localparam logic [7:0] ITVF_RST_WIN_WIDTH_LOW = 8'h00;
  localparam int ITVF_BIT_RESERVED = 7;
  localparam int ITVF_BIT_TOGGLE = 6;
  localparam logic [5:0] ITVF_RST_INT_HIGH = 6'h04;
  localparam logic [7:0] ITVF_RST_INT_LOW = 8'h00;
  localparam logic [5:0] ITVF_RST_VRD_HIGH = 6'h04;
  localparam logic [7:0] ITVF_RST_VRD_LOW = 8'h27;
  localparam logic [5:0] ITVF_RST_VCW_HIGH = 6'h05;
  localparam logic [7:0] ITVF_RST_VCW_LOW = 8'h00;
  localparam logic [13:0] ITVF_ONE_14 = 14'h0001;
  typedef logic [13:0] itvf_count_t;
  // One register write from the serial link front end
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } itvf_wr_s;
  // Active frame geometry seen by the timing generator
  typedef struct packed {
    itvf_count_t rows;
    itvf_count_t cols;
    itvf_count_t exposure;
  } itvf_geom_s;
endpackage

/* File: hw/itvf_reg_mem.sv */
// Small byte store for the virtual frame size registers, registered read data
`timescale 1ns/10ps
module itvf_reg_mem
  import itvf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  output logic [13:0] rows_o,
  output logic [13:0] cols_o
);
  logic [7:0] mem_reg [4];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_reg[0] <= {2'h0, ITVF_RST_VRD_HIGH};
      mem_reg[1] <= ITVF_RST_VRD_LOW;
      mem_reg[2] <= {2'h0, ITVF_RST_VCW_HIGH};
      mem_reg[3] <= ITVF_RST_VCW_LOW;
    end
    else if (wr_en_i)
    begin
      // High bytes keep only six bits; unused bits read as zero
      mem_reg[wr_idx_i] <= wr_idx_i[0] ? wr_data_i : {2'h0, wr_data_i[5:0]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= mem_reg[rd_idx_i];
  end

  assign rows_o = {mem_reg[0][5:0], mem_reg[1]};
  assign cols_o = {mem_reg[2][5:0], mem_reg[3]};
endmodule // itvf_reg_mem

/* File: sim/itvf_host.sv */
// Host model issuing register writes and reads at the falling edge
`timescale 1ns/10ps
module itvf_host
  import itvf_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output itvf_wr_s wr_o,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o
);
  logic tog_reg = 1'b0;
  initial wr_o = '0;
  initial rd_en_o = 1'b0;
  initial rd_addr_o = 8'h00;
  // Released bus shows inverted values, never the stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = '{1'b1, a, d};
    @(negedge clk_i);
    wr_o = '{1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
    // Answer stands two edges after the request
    @(negedge clk_i);
    d = rd_data_i;
    v = rd_valid_i;
  endtask
  task automatic clear_toggle();
    tog_reg = 1'b0;
  endtask
  task automatic set_exposure(input logic [13:0] c, input logic flip);
    wr(ITVF_ADDR_INT_LOW, c[7:0]);
    tog_reg = tog_reg ^ flip;
    wr(ITVF_ADDR_INT_HIGH, {1'b0, tog_reg, c[13:8]});
  endtask
endmodule // itvf_host

/* File: sim/testbench.sv */
// Self-checking bench for the exposure and frame size register block
`timescale 1ns/10ps
module testbench
  import itvf_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic frame_end_i = 1'b0;
  itvf_wr_s wr_i;
  itvf_geom_s geom_o;
  logic rd_en_i, rd_valid_o, toggle_o, v;
  logic [7:0] rd_addr_i, rd_data_o, d;
  logic [13:0] brow, bcol, cnt, vrd, exp_q;
  logic [10:0] win;
  int bad_count = 0;
  int cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  itvf_host host (.clk_i(clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .wr_o(wr_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i));
  itvf_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .frame_end_i(frame_end_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .geom_o(geom_o), .blank_rows_base_o(brow),
    .blank_cols_base_o(bcol), .toggle_o(toggle_o));
  function automatic logic [13:0] plus1(input logic [13:0] c);
    return c + 14'h0001;
  endfunction
  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    chk("rd_valid_o", 14'h0001, {13'h0, v});
    chk("rd_data_o", {6'h0, e}, {6'h0, d});
  endtask
  // Values every reset must restore, checked after the first edge
  task automatic check_reset_state();
    chk("rows", 14'h0428, geom_o.rows);
    chk("cols", 14'h0501, geom_o.cols);
    chk("exposure", plus1(14'h0400), geom_o.exposure);
    chk("toggle_o", 14'h0000, {13'h0, toggle_o});
    chk("blank_rows_base", 14'h0000, brow);
    chk("blank_cols_base", 14'h0000, bcol);
    rchk(ITVF_ADDR_INT_HIGH, 8'h04);
    rchk(ITVF_ADDR_INT_LOW, 8'h00);
    rchk(ITVF_ADDR_VRD_HIGH, 8'h04);
    rchk(ITVF_ADDR_WIN_WIDTH_HIGH, {5'h00, ITVF_RST_WIN_WIDTH_HIGH});
  endtask
  task automatic pulse_frame_end();
    @(negedge clk_i);
    frame_end_i = 1'b1;
    @(negedge clk_i);
    frame_end_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard, far above the real run length
  initial
  begin
    #100us;
    bad_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(75397));
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check_reset_state();
    rchk(8'h60, 8'h00);
    $display("done: reset values");
    exp_q = 14'h0400;
    // Pass 3 keeps the toggle, so nothing may commit
    for (int i = 0; i < 20; i++)
    begin
      cnt = (i == 1) ? 14'h3ffe : 14'($urandom) & {13'h1fff, i[0]};
      host.set_exposure(cnt, i != 3);
      chk("exposure", plus1(exp_q), geom_o.exposure);
      pulse_frame_end();
      if (i != 3)
        exp_q = cnt;
      chk("exposure", plus1(exp_q), geom_o.exposure);
      chk("toggle_o", {13'h0, host.tog_reg}, {13'h0, toggle_o});
      rchk(ITVF_ADDR_INT_LOW, cnt[7:0]);
    end
    // Frame ends between the two bytes: the old count must stay whole
    cnt = 14'($urandom);
    host.wr(ITVF_ADDR_INT_LOW, cnt[7:0]);
    pulse_frame_end();
    chk("exposure", plus1(exp_q), geom_o.exposure);
    host.set_exposure(cnt, 1'b1);
    pulse_frame_end();
    exp_q = cnt;
    chk("exposure", plus1(exp_q), geom_o.exposure);
    $display("done: exposure updates");
    // Tiny frames included: no clamping expected
    for (int i = 0; i < 8; i++)
    begin
      vrd = (i == 0) ? 14'h0000 : 14'($urandom) & 14'h3ffe;
      host.wr(ITVF_ADDR_VRD_HIGH, {2'b11, vrd[13:8]});
      host.wr(ITVF_ADDR_VRD_LOW, vrd[7:0]);
      host.wr(ITVF_ADDR_VCW_HIGH, {2'b11, ~vrd[13:8]});
      host.wr(ITVF_ADDR_VCW_LOW, ~vrd[7:0]);
      repeat (2) @(negedge clk_i);
      chk("rows", plus1(vrd), geom_o.rows);
      chk("cols", plus1(~vrd), geom_o.cols);
      chk("exposure", plus1(exp_q), geom_o.exposure);
      rchk(ITVF_ADDR_VRD_HIGH, {2'b00, vrd[13:8]});
    end
    $display("done: frame size");
    // Window width writes must never move the exposure
    for (int i = 0; i < 4; i++)
    begin
      win = 11'($urandom);
      host.wr(ITVF_ADDR_WIN_WIDTH_HIGH, {5'h1f, win[10:8]});
      host.wr(ITVF_ADDR_WIN_WIDTH_LOW, win[7:0]);
      pulse_frame_end();
      chk("exposure", plus1(exp_q), geom_o.exposure);
      rchk(ITVF_ADDR_WIN_WIDTH_HIGH, {5'h00, win[10:8]});
      rchk(ITVF_ADDR_WIN_WIDTH_LOW, win[7:0]);
    end
    $display("done: window width");
    // Legal frame again: well over the window in rows and columns
    host.wr(ITVF_ADDR_WIN_WIDTH_HIGH, 8'h00);
    host.wr(ITVF_ADDR_WIN_WIDTH_LOW, 8'h80);
    host.wr(ITVF_ADDR_VRD_HIGH, {2'b00, ITVF_RST_VRD_HIGH});
    host.wr(ITVF_ADDR_VRD_LOW, ITVF_RST_VRD_LOW);
    host.wr(ITVF_ADDR_VCW_HIGH, {2'b00, ITVF_RST_VCW_HIGH});
    host.wr(ITVF_ADDR_VCW_LOW, ITVF_RST_VCW_LOW);
    repeat (2) @(negedge clk_i);
    chk("rows", plus1({ITVF_RST_VRD_HIGH, ITVF_RST_VRD_LOW}), geom_o.rows);
    chk("cols", plus1({ITVF_RST_VCW_HIGH, ITVF_RST_VCW_LOW}), geom_o.cols);
    $display("done: legal frame");
    // Second reset in mid-run: committed toggle and shadows must clear
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    host.clear_toggle();
    @(negedge clk_i);
    check_reset_state();
    rchk(ITVF_ADDR_WIN_WIDTH_LOW, ITVF_RST_WIN_WIDTH_LOW);
    $display("done: second reset");
    conclude();
  end
endmodule // testbench
